//--- logic/acc_read_pkg.sv
// Constants for the register-to-accumulator read instructions
package acc_read_pkg;
  localparam int OP_W = 10;
  localparam int ACC_W = 4;
  localparam int STACK_W = 3;
  localparam int N_SRC = 8;
  // Opcode words for each source register
  localparam logic [OP_W-1:0] OP_CLOCK_CTRL = 10'h252;
  localparam logic [OP_W-1:0] OP_PULLUP0 = 10'h257;
  localparam logic [OP_W-1:0] OP_PULLUP1 = 10'h25e;
  localparam logic [OP_W-1:0] OP_PULLUP2 = 10'h25f;
  localparam logic [OP_W-1:0] OP_STACK_PTR = 10'h250;
  localparam logic [OP_W-1:0] OP_INT_CTRL1 = 10'h054;
  localparam logic [OP_W-1:0] OP_INT_CTRL2 = 10'h055;
  localparam logic [OP_W-1:0] OP_TIMER_CTRL1 = 10'h24b;
  // Source index order used by the select vector
  localparam int SRC_CLOCK = 0;
  localparam int SRC_PULL0 = 1;
  localparam int SRC_PULL1 = 2;
  localparam int SRC_PULL2 = 3;
  localparam int SRC_STACK = 4;
  localparam int SRC_INT1 = 5;
  localparam int SRC_INT2 = 6;
  localparam int SRC_TIMER1 = 7;
  localparam logic [N_SRC*OP_W-1:0] OP_TABLE = {
    OP_TIMER_CTRL1, OP_INT_CTRL2, OP_INT_CTRL1, OP_STACK_PTR,
    OP_PULLUP2, OP_PULLUP1, OP_PULLUP0, OP_CLOCK_CTRL};
  localparam logic [ACC_W-1:0] ACC_RESET = 4'h0;
  localparam logic ACC_TOP_FILL = 1'b0;
endpackage : acc_read_pkg

//--- logic/opcode_match.sv
// Single opcode comparator, qualified by the issue input alone
`timescale 1ns/100ps
`default_nettype none
module opcode_match #(
  parameter int W = 10,
  parameter logic [W-1:0] CODE = '0
) (
  input wire logic [W-1:0] i_opcode,
  input wire logic i_issue,
  output logic o_match
);
  // Full-word compare: no don't-care bits in this group
  assign o_match = i_issue && (i_opcode == CODE);
endmodule : opcode_match
`default_nettype wire

//--- logic/acc_read_decode.sv
// Decode and execute of the register-to-accumulator read instructions
// Functional notes
// [RQ1] Opcode 0x252 copies clock control register to accumulator, one cycle.
// [RQ2] Opcode 0x257 copies pull-up control 0 to accumulator, one cycle.
// [RQ3] A one-cycle opcode copies pull-up control 1 to accumulator.
// [RQ4] Opcode 0x25F copies pull-up control 2 to accumulator, one cycle.
// [RQ5] Stack pointer read fills low three bits, top bit zero.
// [RQ6] Opcode 0x054 copies interrupt control 1 to accumulator.
// [RQ7] Opcode 0x055 copies interrupt control 2 to accumulator.
// [RQ8] Opcode 0x24B copies timer control 1 to accumulator.
// [RQ9] Sources untouched; only accumulator changes, at cycle end; no skip.
`timescale 1ns/100ps
`default_nettype none
module acc_read_decode
  import acc_read_pkg::*;
#(
  parameter int OPW = acc_read_pkg::OP_W,
  parameter int AW = acc_read_pkg::ACC_W,
  parameter int SPW = acc_read_pkg::STACK_W
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_op_valid,
  input wire logic [acc_read_pkg::OP_W-1:0] i_opcode,
  input wire logic i_acc_wr,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_acc_wdata,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_clock_ctrl_reg,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_pullup_ctrl0,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_pullup_ctrl1,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_pullup_ctrl2,
  input wire logic [acc_read_pkg::STACK_W-1:0] i_stack_pointer,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_int_ctrl1,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_int_ctrl2,
  input wire logic [acc_read_pkg::ACC_W-1:0] i_timer_ctrl1,
  output logic o_hit,
  output logic o_carry_we,
  output logic o_skip,
  output logic [acc_read_pkg::ACC_W-1:0] o_acc
);
  import acc_read_pkg::*;

  // The opcode table is fixed at these widths, and the stack pointer
  // must leave room for the forced top bit of the accumulator
  if (OPW != OP_W || AW != ACC_W || SPW != STACK_W || SPW >= AW) begin : g_chk
    $error("acc_read_decode: unsupported width parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic issue;
  logic [N_SRC-1:0] sel;
  // Nothing is taken while the clock enable is low
  assign issue = i_ce && i_op_valid;

  // One comparator per source; at most one can match, since the codes differ
  // A code outside the table matches nothing and leaves the hit low
  for (genvar g = 0; g < N_SRC; g++) begin : g_dec
    opcode_match #(
      .W(OP_W),
      .CODE(OP_TABLE[g*OP_W +: OP_W])
    ) u_match (
      .i_opcode(i_opcode),
      .i_issue(issue),
      .o_match(sel[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source select
  logic [ACC_W-1:0] stack_word;
  logic [ACC_W-1:0] rd_data;
  // Top bit is forced so a stale accumulator bit cannot survive the read
  assign stack_word = {ACC_TOP_FILL, i_stack_pointer}; // RQ5
  // AND-OR mux keeps the path flat; sources are only sampled, never written
  assign rd_data =
      ({ACC_W{sel[SRC_CLOCK]}} & i_clock_ctrl_reg) // RQ1
    | ({ACC_W{sel[SRC_PULL0]}} & i_pullup_ctrl0) // RQ2
    | ({ACC_W{sel[SRC_PULL1]}} & i_pullup_ctrl1) // RQ3
    | ({ACC_W{sel[SRC_PULL2]}} & i_pullup_ctrl2) // RQ4
    | ({ACC_W{sel[SRC_STACK]}} & stack_word) // RQ5
    | ({ACC_W{sel[SRC_INT1]}} & i_int_ctrl1) // RQ6
    | ({ACC_W{sel[SRC_INT2]}} & i_int_ctrl2) // RQ7
    | ({ACC_W{sel[SRC_TIMER1]}} & i_timer_ctrl1); // RQ8

  // Hit wins over a core write in the same cycle
  // Other instructions load the accumulator through the core write port
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W-1:0] acc_q;
  assign o_hit = |sel;
  assign acc_d = o_hit ? rd_data : (i_acc_wr ? i_acc_wdata : acc_q); // RQ9
  // Carry and skip never touched by this group
  assign o_carry_we = 1'b0; // RQ9
  assign o_skip = 1'b0; // RQ9

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator, updated at the cycle end
  // Reset loads a constant; a frozen cycle keeps the old word
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_q <= ACC_RESET;
    end else if (i_ce) begin
      acc_q <= acc_d; // RQ9
    end
  end
  // Data output comes straight from the flip-flop
  assign o_acc = acc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Each read is judged one edge later against the source as it stood
  // when the opcode was taken, so a source that moves afterwards is fine.
  // All checks sleep while reset is held low.
  // Sources are inputs here, so no read can disturb them from this side.

  // Clock control read
  property p_clock_ctrl;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_CLOCK_CTRL) |=> o_acc == $past(i_clock_ctrl_reg);
  endproperty
  a_clock_ctrl: assert property (p_clock_ctrl) // RQ1
    else $error("clock ctrl read wrong");

  // Pull-up control 0 read
  property p_pullup0;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_PULLUP0) |=> o_acc == $past(i_pullup_ctrl0);
  endproperty
  a_pullup0: assert property (p_pullup0) // RQ2
    else $error("pullup0 read wrong");

  // Pull-up control 1 read, with the hit shown in the issue cycle
  property p_pullup1;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_PULLUP1) |-> o_hit ##1
      o_acc == $past(i_pullup_ctrl1);
  endproperty
  a_pullup1: assert property (p_pullup1) // RQ3
    else $error("pullup1 read wrong");

  // Pull-up control 2 read
  property p_pullup2;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_PULLUP2) |=> o_acc == $past(i_pullup_ctrl2);
  endproperty
  a_pullup2: assert property (p_pullup2) // RQ4
    else $error("pullup2 read wrong");

  // Stack pointer read: low bits copied, top bit cleared
  property p_stack_ptr;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_STACK_PTR) |=>
      (o_acc[ACC_W-1] == 1'b0 &&
       o_acc[STACK_W-1:0] == $past(i_stack_pointer));
  endproperty
  a_stack_ptr: assert property (p_stack_ptr) // RQ5
    else $error("stack pointer read wrong");

  // Interrupt control 1 read
  property p_int_ctrl1;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_INT_CTRL1) |=> o_acc == $past(i_int_ctrl1);
  endproperty
  a_int_ctrl1: assert property (p_int_ctrl1) // RQ6
    else $error("int ctrl1 read wrong");

  // Interrupt control 2 read
  property p_int_ctrl2;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_INT_CTRL2) |=> o_acc == $past(i_int_ctrl2);
  endproperty
  a_int_ctrl2: assert property (p_int_ctrl2) // RQ7
    else $error("int ctrl2 read wrong");

  // Timer control 1 read
  property p_timer_ctrl1;
    @(posedge i_clk) disable iff (!i_rstn)
    (issue && i_opcode == OP_TIMER_CTRL1) |=> o_acc == $past(i_timer_ctrl1);
  endproperty
  a_timer_ctrl1: assert property (p_timer_ctrl1) // RQ8
    else $error("timer ctrl1 read wrong");

  // Core write lands when no read of this group claims the cycle
  property p_core_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_ce && !o_hit && i_acc_wr) |=> o_acc == $past(i_acc_wdata);
  endproperty
  a_core_write: assert property (p_core_write) // RQ9
    else $error("core write to accumulator lost");

  // A low clock enable freezes the accumulator
  property p_frozen;
    @(posedge i_clk) disable iff (!i_rstn)
    !i_ce |=> $stable(o_acc);
  endproperty
  a_frozen: assert property (p_frozen) // RQ9
    else $error("accumulator moved while frozen");

  // No hit without a valid instruction and a running clock enable
  property p_idle_quiet;
    @(posedge i_clk) disable iff (!i_rstn)
    !(i_ce && i_op_valid) |-> !o_hit;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // RQ9
    else $error("hit without an issued instruction");

  // A read of this group never writes carry nor asks for a skip
  property p_hit_flags;
    @(posedge i_clk) disable iff (!i_rstn)
    o_hit |-> !o_carry_we && !o_skip;
  endproperty
  a_hit_flags: assert property (p_hit_flags) // RQ9
    else $error("read touched carry or skip");

  // Quiet cycles change nothing at all
  property p_no_side;
    @(posedge i_clk) disable iff (!i_rstn)
    (!i_ce || (!o_hit && !i_acc_wr)) |=> $stable(o_acc)
      && !o_skip && !o_carry_we;
  endproperty
  a_no_side: assert property (p_no_side) // RQ9
    else $error("accumulator changed without cause");
endmodule : acc_read_decode
`default_nettype wire

//--- bench/core_side.sv
// Far-side core model holding the source registers read by the block
`timescale 1ns/100ps
`default_nettype none
module core_side (
  input wire logic [30:0] i_seed,
  output logic [27:0] o_bank,
  output logic [2:0] o_stack
);
  // Sources only change when the core writes them, never on a read
  assign o_bank = i_seed[27:0];
  assign o_stack = i_seed[30:28];
endmodule : core_side
`default_nettype wire

//--- bench/register_to_accumulator_reads_tb.sv
// Self-checking bench for the register-to-accumulator read decoder
`timescale 1ns/100ps
`default_nettype none
module register_to_accumulator_reads_tb;
  import acc_read_pkg::*;
  logic i_clk, i_rstn, ce, vld, wr;
  logic [9:0] op;
  logic [3:0] wd;
  logic [31:0] seed;
  wire logic [27:0] bank;
  wire logic [2:0] stk;
  wire logic hit, cwe, skp;
  wire logic [3:0] acc;
  int errors, n_checks, cyc;
  core_side u_core_side (.i_seed(seed[30:0]), .o_bank(bank), .o_stack(stk));
  acc_read_decode u_acc_read_decode (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_ce(ce), .i_op_valid(vld), .i_opcode(op), .i_acc_wr(wr),
    .i_acc_wdata(wd), .i_clock_ctrl_reg(bank[3:0]),
    .i_pullup_ctrl0(bank[7:4]), .i_pullup_ctrl1(bank[11:8]),
    .i_pullup_ctrl2(bank[15:12]), .i_stack_pointer(stk),
    .i_int_ctrl1(bank[19:16]), .i_int_ctrl2(bank[23:20]),
    .i_timer_ctrl1(bank[27:24]), .o_hit(hit), .o_carry_we(cwe),
    .o_skip(skp), .o_acc(acc));
  ////////////////////////////////////////////////////////////////////
  // Expected accumulator per table slot, from the seed alone
  function automatic logic [3:0] exp_of(input int i);
    case (i)
      0: return seed[3:0];
      1: return seed[7:4];
      2: return seed[11:8];
      3: return seed[15:12];
      4: return {1'b0, seed[30:28]};
      5: return seed[19:16];
      6: return seed[23:20];
      default: return seed[27:24];
    endcase
  endfunction : exp_of
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Drive one cycle just after the edge, then let outputs settle
  task automatic step(input logic [9:0] o, input logic v, input logic c,
                      input logic w, input logic [3:0] d);
    @(posedge i_clk);
    op <= o;
    vld <= v;
    ce <= c;
    wr <= w;
    wd <= d;
    #1;
  endtask : step
  ////////////////////////////////////////////////////////////////////
  // Back-to-back reads of all eight sources; top stack seed bit set
  task automatic t_reads;
    seed <= 32'hd83c_5e71;
    for (int i = 0; i < 8; i++) begin
      step(OP_TABLE[i*OP_W +: OP_W], 1'b1, 1'b1, 1'b0, 4'h0);
      check({3'h0, hit}, 4'h1);
      check({2'h0, cwe, skp}, 4'h0);
      if (i > 0) check(acc, exp_of(i - 1));
    end
    step(10'h000, 1'b0, 1'b1, 1'b0, 4'h0);
    check(acc, exp_of(7));
  endtask : t_reads
  // Stack read over a full accumulator must clear the top bit
  task automatic t_stack;
    step(10'h000, 1'b0, 1'b1, 1'b1, 4'hf);
    seed <= 32'h7000_0000;
    step(OP_STACK_PTR, 1'b1, 1'b1, 1'b0, 4'h0);
    check(acc, 4'hf);
    step(OP_TIMER_CTRL1, 1'b1, 1'b1, 1'b1, 4'h3);
    check(acc, 4'h7);
    step(10'h000, 1'b0, 1'b1, 1'b0, 4'h0);
    check(acc, 4'h0);
  endtask : t_stack
  // Near-miss opcode and a frozen core leave the accumulator alone
  task automatic t_refuse;
    step(10'h000, 1'b0, 1'b1, 1'b1, 4'ha);
    step(OP_CLOCK_CTRL, 1'b1, 1'b0, 1'b1, 4'h5);
    check({3'h0, hit}, 4'h0);
    step(10'h253, 1'b1, 1'b1, 1'b0, 4'h0);
    check({3'h0, hit}, 4'h0);
    step(10'h000, 1'b0, 1'b1, 1'b0, 4'h0);
    check(acc, 4'ha);
  endtask : t_refuse
  // Reset in mid-run clears the accumulator; a read may follow at once
  task automatic t_reset;
    seed <= 32'h0006_0000;
    step(10'h000, 1'b0, 1'b1, 1'b1, 4'h9);
    step(10'h000, 1'b0, 1'b1, 1'b0, 4'h0);
    check(acc, 4'h9);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    #1;
    check(acc, ACC_RESET);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    op <= OP_INT_CTRL1;
    vld <= 1'b1;
    #1;
    check(acc, ACC_RESET);
    step(10'h000, 1'b0, 1'b1, 1'b0, 4'h0);
    check(acc, exp_of(5));
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // Clock and hang guard; the whole run needs well under 100 cycles
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    {i_rstn, ce, vld, wr, op, wd, seed} = '0;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1;
    check(acc, ACC_RESET);
    t_reads();
    t_stack();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule : register_to_accumulator_reads_tb
`default_nettype wire
